// file: enclave_check_map.svh
`ifndef ENCLAVE_CHECK_MAP_SVH
`define ENCLAVE_CHECK_MAP_SVH

// Leaf numbers decoded by this unit
`define LEAF_ENTER          8'h02
`define LEAF_RESUME         8'h03
`define LEAF_EXIT           8'h04
`define LEAF_DEBUG_READ     8'h04
`define LEAF_DEBUG_WRITE    8'h05

// Feature control register fields
`define FC_LOCK_BIT         0
`define FC_ENABLE_BIT       18

// Capability register fields
`define CAP2_LEAF_EXIT_BIT  15
`define MISC_ENTRY_LEN_BIT  30
`define MAX_ENTRY_LEN       4'hF

// Privilege and address constants
`define CPL_USER            2'h3
`define ADDR32_MASK         64'h0000_0000_FFFF_FFFF
`define ZERO64              64'h0000_0000_0000_0000
`define ZERO32              32'h0000_0000
`define ZERO8               8'h00
`define ZERO4               4'h0

`endif

// file: enclave_check_pkg.sv
package enclave_check_pkg;

   typedef enum logic [2:0] {
      KIND_USER,
      KIND_SUPER,
      KIND_SEG_WRITE,
      KIND_WR_FS_BASE,
      KIND_WR_GS_BASE,
      KIND_ASYNC_EXIT,
      KIND_OTHER
   } instr_kind_t;

   typedef struct packed {
      logic [63:0] base;
      logic [31:0] limit;
      logic [7:0]  attr;
   } seg_t;

   typedef struct packed {
      logic        valid;
      instr_kind_t kind;
      logic [7:0]  leaf;
      logic        opsize_prefix;
      logic        addrsize_prefix;
      logic        segovr_prefix;
      logic [63:0] offset;
      logic [63:0] wr_value;
   } req_t;

   typedef struct packed {
      logic        protected_mode;
      logic        system_management_mode;
      logic        virtual_8086_mode;
      logic        paging;
      logic        long_mode;
      logic        cs_l;
      logic        cs_d;
      logic [1:0]  current_privilege_level;
      logic        guest;
      logic        ds_usable;
      logic        ds_expand_down;
      seg_t        ds;
      logic [3:0]  other_seg_base_nonzero;
      logic [63:0] feature_control;
      logic        enclave_feature;
   } cpu_t;

   typedef struct packed {
      logic [63:0] enclave_base;
      logic        enclave_64bit_attribute;
      logic [63:0] thread_fs_base_offset;
      logic [31:0] thread_fs_limit;
      logic [63:0] thread_gs_base_offset;
      logic [31:0] thread_gs_limit;
      logic [63:0] frame_fs_base;
      logic [63:0] frame_gs_base;
   } thread_t;

   typedef struct packed {
      logic        done;
      logic        undefined_opcode_fault;
      logic        general_protection_fault_zero;
      logic        vm_exit;
      logic        addr64;
      logic [63:0] lin_addr;
      logic        paging_check;
      logic        ad_update_ok;
   } result_t;

   typedef struct packed {
      logic        frame_write;
      logic [63:0] fs_segment_base_value;
      logic [63:0] gs_segment_base_value;
   } frame_store_t;

   typedef struct packed {
      logic         in_enclave;
      logic         enc64;
      seg_t         fs;
      seg_t         gs;
      seg_t         fs_saved;
      seg_t         gs_saved;
      result_t      res;
      frame_store_t store;
      logic         entry_len_fault;
   } state_t;

endpackage

// file: enclave_check.sv
`timescale 1ns/10ps
`include "enclave_check_map.svh"

module enclave_check (
   // Clock and reset
   input  wire logic                            clock,
   input  wire logic                            rstn,
   // Instruction request and processor state
   input  wire enclave_check_pkg::req_t         req,
   input  wire enclave_check_pkg::cpu_t         cpu,
   input  wire enclave_check_pkg::thread_t      thread,
   input  wire logic                            page_fault,
   // Hypervisor per-leaf permission for guests
   input  wire logic [63:0]                     guest_leaf_allow,
   // Virtual machine entry length check
   input  wire logic                            vm_entry,
   input  wire logic [3:0]                      vm_entry_len,
   // Results
   output enclave_check_pkg::result_t           result,
   output enclave_check_pkg::frame_store_t      frame_store,
   output logic                                 entry_len_fault,
   // Enclave state
   output logic                                 in_enclave,
   output enclave_check_pkg::seg_t              fs_seg,
   output enclave_check_pkg::seg_t              gs_seg,
   // Capability bits
   output logic [31:0]                          secondary_exec_ctrl_capability,
   output logic [31:0]                          misc_virt_capability
);
   import enclave_check_pkg::*;

   state_t state_r;
   state_t state_nxt;

   function automatic logic is_entry(input logic [7:0] leaf);
      is_entry = (leaf == `LEAF_ENTER) || (leaf == `LEAF_RESUME);
   endfunction

   function automatic logic is_debug(input logic [7:0] leaf);
      is_debug = (leaf == `LEAF_DEBUG_READ) || (leaf == `LEAF_DEBUG_WRITE);
   endfunction

   // New segment must lie inside the data segment range
   function automatic logic within_ds(input seg_t s, input seg_t ds);
      logic [64:0] s_end;
      logic [64:0] d_end;
      s_end = {1'b0, s.base} + {33'h0_0000_0000, s.limit};
      d_end = {1'b0, ds.base} + {33'h0_0000_0000, ds.limit};
      within_ds = (s.base >= ds.base) && (s_end <= d_end);
   endfunction

   logic        mode64;
   logic        available;
   logic        ds_ok;
   logic        mode_match;
   logic [63:0] offset_eff;
   logic [63:0] lin_addr;
   seg_t        new_fs;
   seg_t        new_gs;

   always_comb begin
      mode64        = cpu.long_mode && cpu.cs_l;
      // Availability depends on mode, feature control and the enclave feature, not on guest or host
      available = cpu.protected_mode && !cpu.system_management_mode && !cpu.virtual_8086_mode
                  && cpu.feature_control[`FC_ENABLE_BIT] && cpu.feature_control[`FC_LOCK_BIT]
                  && cpu.enclave_feature;
      ds_ok      = cpu.ds_usable && !cpu.ds_expand_down;
      // Code mode must equal the mode the enclave was built for
      mode_match = (mode64 == thread.enclave_64bit_attribute);
      // Prefix ignored: 64-bit in 64-bit mode, else always 32-bit, even for 16-bit code
      offset_eff = mode64 ? req.offset : (req.offset & `ADDR32_MASK);
      lin_addr   = cpu.ds.base + offset_eff;
      if (!mode64) begin
         lin_addr = lin_addr & `ADDR32_MASK;
      end
      new_fs.base  = thread.enclave_base + thread.thread_fs_base_offset;
      new_fs.limit = thread.thread_fs_limit;
      new_fs.attr  = cpu.ds.attr;
      new_gs.base  = thread.enclave_base + thread.thread_gs_base_offset;
      new_gs.limit = thread.thread_gs_limit;
      new_gs.attr  = cpu.ds.attr;
      if (req.leaf == `LEAF_RESUME) begin
         // Resume brings back bases the enclave may have rewritten
         new_fs.base = thread.frame_fs_base;
         new_gs.base = thread.frame_gs_base;
      end
   end

   always_comb begin
      state_nxt                   = state_r;
      state_nxt.res.done          = 1'b0;
      state_nxt.store.frame_write = 1'b0;
      state_nxt.entry_len_fault   = 1'b0;

      if (vm_entry && misc_virt_capability[`MISC_ENTRY_LEN_BIT]) begin
         state_nxt.entry_len_fault = vm_entry_len > `MAX_ENTRY_LEN;
      end

      if (req.valid) begin
         state_nxt.res.done                          = 1'b1;
         state_nxt.res.undefined_opcode_fault        = 1'b0;
         state_nxt.res.general_protection_fault_zero = 1'b0;
         state_nxt.res.vm_exit                       = 1'b0;
         state_nxt.res.addr64                        = mode64;
         state_nxt.res.lin_addr                      = `ZERO64;
         state_nxt.res.paging_check                  = 1'b0;
         state_nxt.res.ad_update_ok                  = 1'b0;

         case (req.kind)
            KIND_USER,
            KIND_SUPER: begin
               if (!available) begin
                  state_nxt.res.undefined_opcode_fault = 1'b1;
               // Exit and debug read share a code; only supervisor debug leaves may skip paging
               end else if (!cpu.paging && !(req.kind == KIND_SUPER && is_debug(req.leaf))) begin
                  state_nxt.res.undefined_opcode_fault = 1'b1;
               end else if (req.opsize_prefix) begin
                  state_nxt.res.undefined_opcode_fault = 1'b1;
               end else if (!ds_ok) begin
                  state_nxt.res.general_protection_fault_zero = 1'b1;
               end else if (req.kind == KIND_SUPER && cpu.guest && !guest_leaf_allow[req.leaf[5:0]]) begin
                  // User leaves in a guest take the same path as on the host
                  state_nxt.res.vm_exit = 1'b1;
               end else if (req.kind == KIND_USER && is_entry(req.leaf)) begin
                  if (cpu.current_privilege_level != `CPL_USER || !mode_match) begin
                     state_nxt.res.general_protection_fault_zero = 1'b1;
                  end else if (cpu.other_seg_base_nonzero != `ZERO4) begin
                     state_nxt.res.general_protection_fault_zero = 1'b1;
                  end else if (!within_ds(new_fs, cpu.ds) || !within_ds(new_gs, cpu.ds)) begin
                     state_nxt.res.general_protection_fault_zero = 1'b1;
                  end else begin
                     state_nxt.in_enclave = 1'b1;
                     state_nxt.enc64      = thread.enclave_64bit_attribute;
                     state_nxt.fs_saved   = state_r.fs;
                     state_nxt.gs_saved   = state_r.gs;
                     state_nxt.fs         = new_fs;
                     state_nxt.gs         = new_gs;
                  end
               end else if (req.kind == KIND_USER && req.leaf == `LEAF_EXIT && state_r.in_enclave) begin
                  state_nxt.in_enclave = 1'b0;
                  state_nxt.fs         = state_r.fs_saved;
                  state_nxt.gs         = state_r.gs_saved;
               end
               if (!state_nxt.res.undefined_opcode_fault && !state_nxt.res.general_protection_fault_zero
                   && !state_nxt.res.vm_exit) begin
                  // Segment override never changes the operand segment
                  state_nxt.res.lin_addr     = lin_addr;
                  state_nxt.res.paging_check = cpu.paging;
                  state_nxt.res.ad_update_ok = cpu.paging && !page_fault;
               end
            end
            KIND_SEG_WRITE: begin
               state_nxt.res.undefined_opcode_fault = state_r.in_enclave;
            end
            KIND_WR_FS_BASE: begin
               if (state_r.in_enclave && !state_r.enc64) begin
                  state_nxt.res.undefined_opcode_fault = 1'b1;
               end else begin
                  state_nxt.fs.base = req.wr_value;
               end
            end
            KIND_WR_GS_BASE: begin
               if (state_r.in_enclave && !state_r.enc64) begin
                  state_nxt.res.undefined_opcode_fault = 1'b1;
               end else begin
                  state_nxt.gs.base = req.wr_value;
               end
            end
            KIND_ASYNC_EXIT: begin
               if (state_r.in_enclave) begin
                  // Frame gets the live bases, including any rewritten ones
                  state_nxt.store.frame_write           = 1'b1;
                  state_nxt.store.fs_segment_base_value = state_r.fs.base;
                  state_nxt.store.gs_segment_base_value = state_r.gs.base;
                  state_nxt.in_enclave                  = 1'b0;
                  state_nxt.fs                          = state_r.fs_saved;
                  state_nxt.gs                          = state_r.gs_saved;
               end
            end
            default: begin
               state_nxt.res.done = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign result          = state_r.res;
   assign frame_store     = state_r.store;
   assign entry_len_fault = state_r.entry_len_fault;
   assign in_enclave      = state_r.in_enclave;
   assign fs_seg          = state_r.fs;
   assign gs_seg          = state_r.gs;

   always_comb begin
      secondary_exec_ctrl_capability                      = `ZERO32;
      secondary_exec_ctrl_capability[`CAP2_LEAF_EXIT_BIT] = cpu.enclave_feature;
      misc_virt_capability                                = `ZERO32;
      misc_virt_capability[`MISC_ENTRY_LEN_BIT]           = 1'b1;
   end

endmodule

// file: enclave_check_sva.sv
`timescale 1ns/10ps
`include "enclave_check_map.svh"
module enclave_check_sva
   import enclave_check_pkg::*;
(
   // Clock and reset
   input wire logic         clock,
   input wire logic         rstn,
   // Watched ports
   input wire req_t         req,
   input wire cpu_t         cpu,
   input wire result_t      result,
   input wire frame_store_t frame_store,
   input wire logic         in_enclave,
   input wire seg_t         fs_seg,
   input wire logic [31:0]  secondary_exec_ctrl_capability,
   input wire logic [31:0]  misc_virt_capability
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   wire enc = req.valid && (req.kind == KIND_USER || req.kind == KIND_SUPER);
   wire avail = cpu.protected_mode && !cpu.system_management_mode && !cpu.virtual_8086_mode && cpu.feature_control[`FC_ENABLE_BIT]
                && cpu.feature_control[`FC_LOCK_BIT] && cpu.enclave_feature;
   wire mode64 = cpu.long_mode && cpu.cs_l;
   wire [63:0] fs_base_w = fs_seg.base;
   sequence s_async_exit;
      req.valid && req.kind == KIND_ASYNC_EXIT && in_enclave;
   endsequence
   sequence s_bases_stored;
      frame_store.frame_write && frame_store.fs_segment_base_value == $past(fs_base_w) ##0 !in_enclave;
   endsequence
   a_done_pulse: assert property (req.valid |=> result.done)
      else $error("request not answered next cycle");
   a_done_idle: assert property (!req.valid |=> !result.done)
      else $error("done without request");
   a_opsize_ud: assert property (enc && req.opsize_prefix |=> result.undefined_opcode_fault)
      else $error("operand-size prefix did not fault");
   a_mode_ud: assert property (enc && !avail |=> result.undefined_opcode_fault)
      else $error("illegal mode did not fault");
   a_paging_ud: assert property (enc && !cpu.paging
      && (req.kind == KIND_USER || (req.leaf != `LEAF_DEBUG_READ && req.leaf != `LEAF_DEBUG_WRITE))
      |=> result.undefined_opcode_fault) else $error("paging off did not fault");
   a_ds_gp: assert property (enc && avail && cpu.paging && !req.opsize_prefix
      && (!cpu.ds_usable || cpu.ds_expand_down) |=> result.general_protection_fault_zero
      && !result.undefined_opcode_fault) else $error("bad data segment not reported");
   a_addr_size: assert property (enc |=> result.addr64 == $past(mode64))
      else $error("address size not from mode");
   a_seg_write: assert property (req.valid && req.kind == KIND_SEG_WRITE && in_enclave
      |=> result.undefined_opcode_fault) else $error("segment write inside enclave allowed");
   a_async_store: assert property (s_async_exit |=> s_bases_stored)
      else $error("async exit did not store bases");
   a_cap_mirror: assert property (secondary_exec_ctrl_capability[`CAP2_LEAF_EXIT_BIT] == cpu.enclave_feature)
      else $error("capability bit does not mirror feature");
   a_misc_bit: assert property (misc_virt_capability[`MISC_ENTRY_LEN_BIT])
      else $error("entry length capability bit clear");
endmodule
bind enclave_check enclave_check_sva chk (.clock, .rstn, .req, .cpu, .result, .frame_store, .in_enclave, .fs_seg,
   .secondary_exec_ctrl_capability, .misc_virt_capability);

// file: enclave_check_tb.sv
`timescale 1ns/10ps
`include "enclave_check_map.svh"
module enclave_check_tb;
   import enclave_check_pkg::*;
   logic         clock = 1'b0;
   logic         rstn = 1'b0;
   req_t         req;
   cpu_t         cpu;
   cpu_t         base_cpu;
   thread_t      thread;
   logic         page_fault = 1'b0;
   logic [63:0]  guest_leaf_allow = 64'h0;
   logic         vm_entry = 1'b0;
   logic [3:0]   vm_entry_len = 4'h0;
   result_t      result;
   frame_store_t frame_store;
   logic         entry_len_fault;
   logic         in_enclave;
   seg_t         fs_seg;
   seg_t         gs_seg;
   logic [31:0]  sec_cap;
   logic [31:0]  misc_cap;
   int           n_mismatch = 0;
   int           checked = 0;
   always #5 clock = ~clock;
   enclave_check dut (.clock(clock), .rstn(rstn), .req(req), .cpu(cpu), .thread(thread), .page_fault(page_fault),
      .guest_leaf_allow(guest_leaf_allow), .vm_entry(vm_entry), .vm_entry_len(vm_entry_len), .result(result),
      .frame_store(frame_store), .entry_len_fault(entry_len_fault), .in_enclave(in_enclave), .fs_seg(fs_seg),
      .gs_seg(gs_seg), .secondary_exec_ctrl_capability(sec_cap), .misc_virt_capability(misc_cap));
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   task automatic conclude;
      $display("mismatches=%0d checks=%0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Valid stays up between calls so back-to-back requests are exercised
   task automatic issue(input instr_kind_t k, input logic [7:0] leaf, input logic [63:0] off);
      req.valid = 1'b1;
      req.kind = k;
      req.leaf = leaf;
      req.offset = off;
      @(negedge clock);
      chk(result.done, 1'b1);
   endtask
   task automatic idle;
      req.valid = 1'b0;
      @(negedge clock);
   endtask
   task automatic t_caps;
      chk(sec_cap, 32'h0000_8000);
      chk(misc_cap, 32'h4000_0000);
      cpu.enclave_feature = 1'b0;
      @(negedge clock);
      chk(sec_cap, 32'h0000_0000);
      cpu = base_cpu;
      vm_entry = 1'b1;
      vm_entry_len = 4'hF;
      @(negedge clock);
      vm_entry = 1'b0;
      chk(entry_len_fault, 1'b0);
   endtask
   task automatic t_faults;
      cpu_t c;
      logic [7:0] lf;
      for (int i = 0; i < 12; i++) begin
         c = base_cpu;
         lf = `LEAF_ENTER;
         req.opsize_prefix = (i == 5);
         c.paging = !(i == 4 || i == 11);
         case (i)
            0: c.virtual_8086_mode = 1'b1;
            1: c.system_management_mode = 1'b1;
            2: c.protected_mode = 1'b0;
            3: c.feature_control[`FC_LOCK_BIT] = 1'b0;
            6: c.ds_expand_down = 1'b1;
            7: c.ds_usable = 1'b0;
            8: c.current_privilege_level = 2'h0;
            9: c.cs_l = 1'b0;
            10: c.other_seg_base_nonzero = 4'h2;
            11: lf = `LEAF_DEBUG_WRITE;
            default: c.current_privilege_level = `CPL_USER;
         endcase
         cpu = c;
         issue(i == 11 ? KIND_SUPER : KIND_USER, lf, 64'h40);
         chk(result.undefined_opcode_fault, i < 6);
         chk(result.general_protection_fault_zero, i >= 6 && i < 11);
         chk(in_enclave, 1'b0);
      end
      req.opsize_prefix = 1'b0;
      cpu = base_cpu;
      idle;
   endtask
   task automatic t_addr32;
      cpu.paging = 1'b0;
      issue(KIND_USER, `LEAF_EXIT, 64'h40);
      chk(result.undefined_opcode_fault, 1'b1);
      issue(KIND_SUPER, `LEAF_DEBUG_READ, 64'h40);
      chk(result.undefined_opcode_fault, 1'b0);
      chk(result.paging_check, 1'b0);
      cpu = base_cpu;
      cpu.long_mode = 1'b0;
      cpu.cs_l = 1'b0;
      issue(KIND_SUPER, 8'h01, 64'h1_0000_0040);
      chk(result.addr64, 1'b0);
      chk(result.lin_addr, 64'h40);
      cpu = base_cpu;
      cpu.guest = 1'b1;
      issue(KIND_SUPER, 8'h01, 64'h40);
      chk(result.vm_exit, 1'b1);
      guest_leaf_allow = 64'h2;
      page_fault = 1'b1;
      issue(KIND_SUPER, 8'h01, 64'h40);
      chk(result.vm_exit, 1'b0);
      chk(result.ad_update_ok, 1'b0);
      page_fault = 1'b0;
      cpu = base_cpu;
      idle;
   endtask
   task automatic t_enclave;
      req.wr_value = 64'hA0;
      issue(KIND_WR_FS_BASE, 8'h00, 64'h0);
      req.segovr_prefix = 1'b1;
      req.addrsize_prefix = 1'b1;
      issue(KIND_USER, `LEAF_ENTER, 64'h40);
      chk(in_enclave, 1'b1);
      chk(fs_seg.base, 64'h1100);
      chk(gs_seg.base, 64'h1200);
      chk(fs_seg.limit, 32'hFF);
      chk(gs_seg.limit, 32'hFF);
      chk(fs_seg.attr, 8'h93);
      chk(result.ad_update_ok, 1'b1);
      chk(result.lin_addr, 64'h40);
      chk(result.addr64, 1'b1);
      chk(result.paging_check, 1'b1);
      issue(KIND_SEG_WRITE, 8'h00, 64'h0);
      chk(result.undefined_opcode_fault, 1'b1);
      req.wr_value = 64'h7700;
      issue(KIND_WR_FS_BASE, 8'h00, 64'h0);
      chk(result.undefined_opcode_fault, 1'b0);
      issue(KIND_ASYNC_EXIT, 8'h00, 64'h0);
      chk(frame_store.frame_write, 1'b1);
      chk(frame_store.fs_segment_base_value, 64'h7700);
      chk(frame_store.gs_segment_base_value, 64'h1200);
      chk(in_enclave, 1'b0);
      chk(fs_seg.base, 64'hA0);
      chk(fs_seg.limit, 32'h0);
      chk(gs_seg.base, 64'h0);
      // Frame memory lives outside the block; hand the stored bases back
      thread.frame_fs_base = frame_store.fs_segment_base_value;
      thread.frame_gs_base = frame_store.gs_segment_base_value;
      issue(KIND_USER, `LEAF_RESUME, 64'h40);
      chk(in_enclave, 1'b1);
      chk(fs_seg.base, 64'h7700);
      chk(gs_seg.base, 64'h1200);
      issue(KIND_USER, `LEAF_EXIT, 64'h40);
      chk(in_enclave, 1'b0);
      chk(fs_seg.base, 64'hA0);
      idle;
   endtask
   initial begin
      req = '0;
      base_cpu = '0;
      base_cpu.protected_mode = 1'b1;
      base_cpu.paging = 1'b1;
      base_cpu.long_mode = 1'b1;
      base_cpu.cs_l = 1'b1;
      base_cpu.current_privilege_level = `CPL_USER;
      base_cpu.ds_usable = 1'b1;
      base_cpu.ds.limit = 32'hFFFF_FFFF;
      base_cpu.ds.attr = 8'h93;
      base_cpu.feature_control = 64'h0000_0000_0004_0001;
      base_cpu.enclave_feature = 1'b1;
      cpu = base_cpu;
      thread = '0;
      thread.enclave_base = 64'h1000;
      thread.enclave_64bit_attribute = 1'b1;
      thread.thread_fs_base_offset = 64'h100;
      thread.thread_fs_limit = 32'hFF;
      thread.thread_gs_base_offset = 64'h200;
      thread.thread_gs_limit = 32'hFF;
      thread.frame_fs_base = 64'h5000;
      thread.frame_gs_base = 64'h6000;
      repeat (16) @(negedge clock);
      rstn = 1'b1;
      @(negedge clock);
      t_caps;
      t_faults;
      t_addr32;
      t_enclave;
      conclude;
   end
   initial begin
      #20000;
      n_mismatch++;
      conclude;
   end
endmodule
